/* verilog/nv_access_ctrl.sv */
// Nonvolatile byte array access controller: control, index and value registers, arming, stalls, ready request.
// Assumes a CPU register port synchronous to i_sys_clk, a power-on reset apart from the system reset,
// and an RC oscillator tick pulse resynchronised to i_sys_clk.
`timescale 1ns/100ps
`include "nv_access_consts.svh"

module nv_access_ctrl #(
    parameter int ADDR_W           = 9,
    parameter int ATOMIC_RC_CYCLES = `NV_ATOMIC_RC_CYCLES,
    parameter int SPLIT_RC_CYCLES  = (`NV_ATOMIC_RC_CYCLES * `NV_SPLIT_TIME_US + `NV_ATOMIC_TIME_US - 1)
                                     / `NV_ATOMIC_TIME_US
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_por_n,
    input  wire logic       i_clk_en,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_global_irq_en,
    input  wire logic       i_selfprog_busy,
    input  wire logic       i_rc_tick,
    output logic      [7:0] o_reg_rdata,
    output logic            o_cpu_stall,
    output logic            o_ready_irq,
    output logic            o_prog_busy
);
    import nv_access_pkg::*;

    localparam int CNT_W = 16;

    initial begin
        if (ADDR_W < 9 || ADDR_W > 16) $error("nv_access_ctrl: ADDR_W must be 9..16");
        if (ATOMIC_RC_CYCLES < 1 || ATOMIC_RC_CYCLES >= (1 << CNT_W)) $error("nv_access_ctrl: bad ATOMIC_RC_CYCLES");
        if (SPLIT_RC_CYCLES < 1 || SPLIT_RC_CYCLES >= (1 << CNT_W)) $error("nv_access_ctrl: bad SPLIT_RC_CYCLES");
    end

    nv_array_if #(.ADDR_W(ADDR_W)) arr ();

    // Software side, cleared by the system reset
    logic [ADDR_W-1:0] idx_q;
    logic [ADDR_W-1:0] idx_d;
    logic [7:0]        value_q;
    logic [7:0]        value_d;
    logic              irq_en_q;
    logic              irq_en_d;
    logic [2:0]        arm_cnt_q;
    logic [2:0]        arm_cnt_d;
    logic [2:0]        stall_cnt_q;
    logic [2:0]        stall_cnt_d;
    logic              rd_pend_q;
    logic              rd_pend_d;
    logic [7:0]        rdata_q;
    logic [7:0]        rdata_d;
    logic              stall_q;
    logic              irq_q;

    // Programming engine; state and latches clear only at power-on so a system reset cannot abort it
    engine_state_t     state_q;
    engine_state_t     state_d;
    prog_mode_t        mode_q;
    prog_mode_t        mode_d;
    prog_mode_t        lat_mode_q;
    prog_mode_t        lat_mode_d;
    logic [ADDR_W-1:0] lat_idx_q;
    logic [ADDR_W-1:0] lat_idx_d;
    logic [7:0]        lat_value_q;
    logic [7:0]        lat_value_d;
    logic              busy_out_q;

    logic              ctrl_wr;
    logic              strobe_ok;
    logic              read_ok;
    logic              busy;
    logic              timer_done;
    logic [CNT_W-1:0]  prog_count;
    prog_mode_t        wr_mode;

    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
        reg_hit = (a == ofs);
    endfunction

    function automatic logic [7:0] ctrl_image(input prog_mode_t m, input logic ie, input logic arm, input logic b);
        ctrl_image                                 = 8'h00;
        ctrl_image[`NV_MODE_MSB:`NV_MODE_LSB]      = m;
        ctrl_image[`NV_BIT_IRQ_EN]                 = ie;
        ctrl_image[`NV_BIT_ARM]                    = arm;
        ctrl_image[`NV_BIT_STROBE]                 = b;
    endfunction

    assign busy    = (state_q == ENG_PROG);
    assign ctrl_wr = i_clk_en && i_reg_wr && reg_hit(i_reg_addr, `NV_CTRL_OFS);
    assign wr_mode = busy ? mode_q : prog_mode_t'(i_reg_wdata[`NV_MODE_MSB:`NV_MODE_LSB]);

    // Reserved mode never starts programming
    assign strobe_ok = ctrl_wr && i_reg_wdata[`NV_BIT_STROBE] && (arm_cnt_q != 3'h0)
                       && !busy && !i_selfprog_busy
                       && (wr_mode != PM_RESERVED);
    assign read_ok   = ctrl_wr && i_reg_wdata[`NV_BIT_READ] && !busy && !strobe_ok;

    // Split modes need half the atomic time or so
    assign prog_count = (wr_mode == PM_ATOMIC) ? CNT_W'(ATOMIC_RC_CYCLES)
                                               : CNT_W'(SPLIT_RC_CYCLES);

    always_comb begin
        idx_d       = idx_q;
        value_d     = value_q;
        irq_en_d    = irq_en_q;
        arm_cnt_d   = arm_cnt_q;
        stall_cnt_d = stall_cnt_q;
        rd_pend_d   = 1'b0;
        rdata_d     = rdata_q;
        if (i_clk_en) begin
            if (arm_cnt_q != 3'h0) begin
                arm_cnt_d = arm_cnt_q - 3'h1;
            end
            if (stall_cnt_q != 3'h0) begin
                stall_cnt_d = stall_cnt_q - 3'h1;
            end
            if (i_reg_wr && reg_hit(i_reg_addr, `NV_IDX_LO_OFS) && !busy) begin
                idx_d[7:0] = i_reg_wdata;
            end
            if (i_reg_wr && reg_hit(i_reg_addr, `NV_IDX_HI_OFS) && !busy) begin
                idx_d[ADDR_W-1:8] = i_reg_wdata[ADDR_W-9:0];
            end
            if (i_reg_wr && reg_hit(i_reg_addr, `NV_DATA_OFS)) begin
                value_d = i_reg_wdata;
            end
            if (ctrl_wr) begin
                irq_en_d = i_reg_wdata[`NV_BIT_IRQ_EN];
                // Arming together with a strobe in one write does not count as arming
                if (i_reg_wdata[`NV_BIT_ARM] && !i_reg_wdata[`NV_BIT_STROBE]) begin
                    arm_cnt_d = `NV_ARM_CYCLES;
                end
            end
            if (strobe_ok) begin
                arm_cnt_d   = 3'h0;
                stall_cnt_d = `NV_WR_STALL_CYCLES;
            end
            if (read_ok) begin
                rd_pend_d   = 1'b1;
                stall_cnt_d = `NV_RD_STALL_CYCLES;
            end
            if (rd_pend_q) begin
                value_d = arr.rd_data;
            end
            if (i_reg_rd) begin
                unique case (1'b1)
                    reg_hit(i_reg_addr, `NV_CTRL_OFS):   rdata_d = ctrl_image(mode_q, irq_en_q,
                                                                              arm_cnt_q != 3'h0, busy);
                    reg_hit(i_reg_addr, `NV_DATA_OFS):   rdata_d = value_q;
                    reg_hit(i_reg_addr, `NV_IDX_LO_OFS): rdata_d = idx_q[7:0];
                    reg_hit(i_reg_addr, `NV_IDX_HI_OFS): rdata_d = 8'(idx_q >> 8);
                    default:                             rdata_d = 8'h00;
                endcase
            end
        end else begin
            rd_pend_d = rd_pend_q;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            idx_q       <= ADDR_W'(`NV_IDX_RESET);
            value_q     <= `NV_DATA_RESET;
            irq_en_q    <= 1'b0;
            arm_cnt_q   <= 3'h0;
            stall_cnt_q <= 3'h0;
            rd_pend_q   <= 1'b0;
            rdata_q     <= 8'h00;
            stall_q     <= 1'b0;
            irq_q       <= 1'b0;
        end else begin
            idx_q       <= idx_d;
            value_q     <= value_d;
            irq_en_q    <= irq_en_d;
            arm_cnt_q   <= arm_cnt_d;
            stall_cnt_q <= stall_cnt_d;
            rd_pend_q   <= rd_pend_d;
            rdata_q     <= rdata_d;
            stall_q     <= (stall_cnt_d != 3'h0);
            // Level request, no sticky flag: it simply follows the idle state
            irq_q       <= irq_en_d && i_global_irq_en
                           && (state_d == ENG_IDLE) && !i_selfprog_busy;
        end
    end

    always_comb begin
        state_d     = state_q;
        mode_d      = mode_q;
        lat_mode_d  = lat_mode_q;
        lat_idx_d   = lat_idx_q;
        lat_value_d = lat_value_q;
        if (!i_rst_n) begin
            // System reset only reaches the mode field when the engine is idle
            if (!busy) begin
                mode_d = prog_mode_t'(`NV_MODE_RESET);
            end
        end else if (i_clk_en) begin
            if (ctrl_wr && !busy) begin
                mode_d = prog_mode_t'(i_reg_wdata[`NV_MODE_MSB:`NV_MODE_LSB]);
            end
            unique case (state_q)
                ENG_IDLE: begin
                    if (strobe_ok) begin
                        state_d     = ENG_PROG;
                        lat_mode_d  = wr_mode;
                        lat_idx_d   = idx_q;
                        lat_value_d = value_q;
                    end
                end
                ENG_PROG: begin
                    if (timer_done) begin
                        state_d = ENG_IDLE;
                    end
                end
            endcase
        end
    end

    // Engine runs on power-on reset so a system reset lets a write finish
    always_ff @(posedge i_sys_clk or negedge i_por_n) begin
        if (!i_por_n) begin
            state_q     <= ENG_IDLE;
            mode_q      <= prog_mode_t'(`NV_MODE_RESET);
            lat_mode_q  <= PM_ATOMIC;
            lat_idx_q   <= ADDR_W'(`NV_IDX_RESET);
            lat_value_q <= `NV_DATA_RESET;
            busy_out_q  <= 1'b0;
        end else begin
            state_q     <= state_d;
            mode_q      <= mode_d;
            lat_mode_q  <= lat_mode_d;
            lat_idx_q   <= lat_idx_d;
            lat_value_q <= lat_value_d;
            busy_out_q  <= (state_d == ENG_PROG);
        end
    end

    nv_prog_timer #(
        .CNT_W(CNT_W)
    ) u_timer (
        .i_sys_clk(i_sys_clk),
        .i_por_n  (i_por_n),
        .i_clk_en (i_clk_en),
        .i_rc_tick(i_rc_tick),
        .i_start  (strobe_ok && state_q == ENG_IDLE && i_rst_n),
        .i_count  (prog_count),
        .o_done   (timer_done)
    );

    assign arr.rd_en       = read_ok;
    assign arr.rd_addr     = idx_q;
    assign arr.commit      = busy && timer_done && i_clk_en;
    assign arr.commit_mode = lat_mode_q;
    assign arr.commit_addr = lat_idx_q;
    assign arr.commit_data = lat_value_q;

    nv_cell_array #(
        .ADDR_W(ADDR_W)
    ) u_cells (
        .i_sys_clk(i_sys_clk),
        .i_rst_n  (i_por_n),
        .i_clk_en (i_clk_en),
        .arr      (arr)
    );

    assign o_reg_rdata = rdata_q;
    assign o_cpu_stall = stall_q;
    assign o_ready_irq = irq_q;
    assign o_prog_busy = busy_out_q;
endmodule // nv_access_ctrl

/* verilog/nv_access_consts.svh */
// Register offsets, field positions, reset values and timing counts of the nonvolatile access block.
// Assumes the CPU data-space register map and a 20 MHz CPU clock.
`ifndef NV_ACCESS_CONSTS_SVH
`define NV_ACCESS_CONSTS_SVH

`define NV_CTRL_OFS        8'h3f
`define NV_DATA_OFS        8'h40
`define NV_IDX_LO_OFS      8'h41
`define NV_IDX_HI_OFS      8'h42

`define NV_BIT_READ        0
`define NV_BIT_STROBE      1
`define NV_BIT_ARM         2
`define NV_BIT_IRQ_EN      3
`define NV_MODE_LSB        4
`define NV_MODE_MSB        5

`define NV_MODE_RESET      2'h0
`define NV_DATA_RESET      8'h00
`define NV_IDX_RESET       16'h0000

`define NV_CLK_PERIOD_NS   50
`define NV_ARM_CYCLES      3'h4
`define NV_WR_STALL_CYCLES 3'h2
`define NV_RD_STALL_CYCLES 3'h4

`define NV_ATOMIC_TIME_US  3400
`define NV_SPLIT_TIME_US   1800
`define NV_ATOMIC_RC_CYCLES 26368

`endif

/* verilog/nv_access_pkg.sv */
// Types shared by the nonvolatile access block and its cell array.
// Assumes the constants header is included by the design files.
package nv_access_pkg;

    typedef enum logic [1:0] {
        PM_ATOMIC   = 2'h0,
        PM_ERASE    = 2'h1,
        PM_WRITE    = 2'h2,
        PM_RESERVED = 2'h3
    } prog_mode_t;

    typedef enum logic {
        ENG_IDLE,
        ENG_PROG
    } engine_state_t;

endpackage

/* verilog/nv_array_if.sv */
// Carrier between the access controller and the cell array.
// Assumes one clock domain shared by both ends.
`timescale 1ns/100ps
interface nv_array_if #(
    parameter int ADDR_W = 9
);
    import nv_access_pkg::*;

    logic              rd_en;
    logic [ADDR_W-1:0] rd_addr;
    logic [7:0]        rd_data;
    logic              commit;
    prog_mode_t        commit_mode;
    logic [ADDR_W-1:0] commit_addr;
    logic [7:0]        commit_data;

    modport ctrl  (output rd_en, rd_addr, commit, commit_mode, commit_addr, commit_data, input rd_data);
    modport array (input rd_en, rd_addr, commit, commit_mode, commit_addr, commit_data, output rd_data);
endinterface

/* verilog/nv_cell_array.sv */
// Byte-wide nonvolatile cell array model with registered read data.
// Assumes commits arrive only when programming time has elapsed.
`timescale 1ns/100ps
`include "nv_access_consts.svh"
module nv_cell_array #(
    parameter int ADDR_W = 9
) (
    input  wire logic  i_sys_clk,
    input  wire logic  i_rst_n,
    input  wire logic  i_clk_en,
    nv_array_if.array  arr
);
    import nv_access_pkg::*;

    logic [7:0] cells [0:(1<<ADDR_W)-1];
    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;
    logic [7:0] cell_new;

    // Write only can clear bits but never set them; erase returns the cell to all ones
    function automatic logic [7:0] cell_result(input prog_mode_t m, input logic [7:0] old_v, input logic [7:0] new_v);
        unique case (m)
            PM_ATOMIC: cell_result = new_v;
            PM_ERASE:  cell_result = 8'hff;
            PM_WRITE:  cell_result = old_v & new_v;
            default:   cell_result = old_v;
        endcase
    endfunction

    always_comb begin
        rd_data_d = rd_data_q;
        if (i_clk_en && arr.rd_en) begin
            rd_data_d = cells[arr.rd_addr];
        end
        cell_new = cell_result(arr.commit_mode, cells[arr.commit_addr], arr.commit_data);
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_clk_en && arr.commit) begin
            cells[arr.commit_addr] <= cell_new;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_data_q <= 8'h00;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end

    assign arr.rd_data = rd_data_q;
endmodule // nv_cell_array

/* verilog/nv_prog_timer.sv */
// Down counter of calibrated RC oscillator ticks that times one programming operation.
// Assumes i_rc_tick is a one-cycle pulse synchronous to i_sys_clk.
`timescale 1ns/100ps
`include "nv_access_consts.svh"
module nv_prog_timer #(
    parameter int CNT_W = 16
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_por_n,
    input  wire logic             i_clk_en,
    input  wire logic             i_rc_tick,
    input  wire logic             i_start,
    input  wire logic [CNT_W-1:0] i_count,
    output logic                  o_done
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             done_q;
    logic             done_d;

    initial begin
        if (CNT_W < 2 || CNT_W > 24) $error("nv_prog_timer: CNT_W out of range");
    end

    always_comb begin
        cnt_d  = cnt_q;
        done_d = 1'b0;
        if (i_clk_en) begin
            if (i_start) begin
                cnt_d = i_count;
            end else if (i_rc_tick && cnt_q != '0) begin
                cnt_d  = cnt_q - 1'b1;
                done_d = (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});
            end
        end else begin
            done_d = done_q;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_por_n) begin
        if (!i_por_n) begin
            cnt_q  <= '0;
            done_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            done_q <= done_d;
        end
    end

    assign o_done = done_q;
endmodule // nv_prog_timer

/* verif/nv_access_ctrl_props.sv */
// Concurrent checks on the ports of the nonvolatile access controller.
// Assumes a bind from the bench top; one clock domain.
`timescale 1ns/100ps
module nv_access_ctrl_props (
    input wire logic       i_sys_clk,
    input wire logic       i_rst_n,
    input wire logic       i_por_n,
    input wire logic       i_clk_en,
    input wire logic       i_reg_wr,
    input wire logic       i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic       i_global_irq_en,
    input wire logic       i_selfprog_busy,
    input wire logic [7:0] o_reg_rdata,
    input wire logic       o_cpu_stall,
    input wire logic       o_ready_irq,
    input wire logic       o_prog_busy
);
    logic [2:0] arm_age_q, arm_age_d;
    logic       irq_en_q, irq_en_d;
    logic       ctl_wr, ctl_rd, strobe_ok;
    assign ctl_wr = i_reg_wr && i_clk_en && i_reg_addr == 8'h3f;
    assign ctl_rd = i_reg_rd && i_clk_en && i_reg_addr == 8'h3f;
    assign strobe_ok = ctl_wr && i_reg_wdata[1] && i_reg_wdata[5:4] != 2'h3 && arm_age_q != 3'h0
                       && arm_age_q < 3'h4 && !i_selfprog_busy && !o_prog_busy;
    // Age saturates so a long-expired arm never looks fresh again
    always_comb begin
        // Age freezes with the clock enable, as the design's arm counter does
        arm_age_d = (i_clk_en && arm_age_q != 3'h0 && arm_age_q != 3'h7) ? arm_age_q + 3'h1 : arm_age_q;
        if (ctl_wr && i_reg_wdata[2] && !i_reg_wdata[1]) begin
            arm_age_d = 3'h1;
        end
        irq_en_d = ctl_wr ? i_reg_wdata[3] : irq_en_q;
    end
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            arm_age_q <= 3'h0;
            irq_en_q  <= 1'b0;
        end else begin
            arm_age_q <= arm_age_d;
            irq_en_q  <= irq_en_d;
        end
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n || !i_por_n);
    sequence s_wr_stall;
        o_cpu_stall [*2] ##1 !o_cpu_stall;
    endsequence
    sequence s_rd_stall;
        o_cpu_stall [*4] ##1 !o_cpu_stall;
    endsequence
    a_strobe_starts: assert property (strobe_ok |=> (o_prog_busy ##0 s_wr_stall))
        else $error("accepted write strobe did not start programming with a two cycle stall");
    a_busy_cause: assert property ($rose(o_prog_busy) |-> $past(ctl_wr && i_reg_wdata[1]
        && arm_age_q != 3'h0 && arm_age_q < 3'h5 && !i_selfprog_busy))
        else $error("programming began without an armed strobe");
    a_read_stall: assert property (ctl_wr && i_reg_wdata[0] && !i_reg_wdata[1] && !o_prog_busy |=> s_rd_stall)
        else $error("read strobe stall not four cycles");
    a_busy_no_read: assert property (ctl_wr && i_reg_wdata[0] && o_prog_busy |=> !o_cpu_stall)
        else $error("read strobe taken while programming");
    a_irq_quiet: assert property (o_prog_busy || $past(i_selfprog_busy) |-> !o_ready_irq)
        else $error("ready request during programming");
    a_irq_level: assert property ((irq_en_q && i_global_irq_en && !o_prog_busy && !i_selfprog_busy) [*3]
        |-> o_ready_irq)
        else $error("ready request missing while idle and enabled");
    a_irq_gated: assert property (!i_global_irq_en [*2] |-> !o_ready_irq)
        else $error("ready request with global enable clear");
    a_status_read: assert property (ctl_rd |=> o_reg_rdata[1] == $past(o_prog_busy)
        && o_reg_rdata[7:6] == 2'h0 && !o_reg_rdata[0])
        else $error("control read does not show busy state");
    a_arm_expires: assert property (ctl_rd && arm_age_q > 3'h4 |=> !o_reg_rdata[2])
        else $error("arm bit outlived four cycles");
endmodule // nv_access_ctrl_props

/* verif/cpu_port_model.sv */
// Register port model of the processor core.
// Assumes one clock shared with the controller; a stalled core issues nothing.
`timescale 1ns/100ps
module cpu_port_model (
    input  wire logic       i_sys_clk,
    input  wire logic       i_stall,
    output logic            o_wr = 1'b0,
    output logic            o_rd = 1'b0,
    output logic      [7:0] o_addr = 8'h00,
    output logic      [7:0] o_wdata = 8'h00
);
    // One call drives one cycle; idle calls from wr and rd pass inverted values so stale lines never look valid
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] v);
        int n;
        @(negedge i_sys_clk);
        for (n = 0; n < 16 && i_stall !== 1'b0; n++) begin
            @(negedge i_sys_clk);
        end
        @(posedge i_sys_clk);
        o_wr    <= w;
        o_rd    <= r;
        o_addr  <= a;
        o_wdata <= v;
    endtask
endmodule // cpu_port_model

/* verif/nv_access_ctrl_test.sv */
// Self-checking bench for the nonvolatile access controller.
// Assumes the core port model drives the register bus; RC ticks come every other cycle.
`timescale 1ns/100ps
module nv_access_ctrl_test;
    import nv_access_pkg::*;
    localparam int AT_N = 20;
    localparam int SP_N = 10;
    logic       i_sys_clk = 1'b0, i_rst_n = 1'b0, i_por_n = 1'b0, i_clk_en = 1'b1, i_rc_tick = 1'b0;
    logic       i_global_irq_en = 1'b0, i_selfprog_busy = 1'b0, i_reg_wr, i_reg_rd;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, d;
    logic       o_cpu_stall, o_ready_irq, o_prog_busy;
    int         fails = 0, tests_run = 0, blen = 0, i;
    logic [7:0] ra[8] = '{8'h41, 8'h42, 8'h40, 8'h3f, 8'h3f, 8'h3f, 8'h43, 8'h3e};
    logic [7:0] rw[8] = '{8'ha5, 8'hff, 8'h3c, 8'h38, 8'h20, 8'h00, 8'h55, 8'hff};
    logic [7:0] re[8] = '{8'ha5, 8'h01, 8'h3c, 8'h38, 8'h20, 8'h00, 8'h00, 8'h00};
    prog_mode_t pm[3] = '{PM_ATOMIC, PM_ERASE, PM_WRITE};
    logic [7:0] cv[3] = '{8'h5a, 8'h00, 8'h3c};
    logic [7:0] ce[3] = '{8'h5a, 8'hff, 8'h3c};
    always #25 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) i_rc_tick <= ~i_rc_tick;
    always @(posedge i_sys_clk) blen <= (o_prog_busy === 1'b1) ? blen + 1 : 0;
    cpu_port_model cpu (.i_sys_clk(i_sys_clk), .i_stall(o_cpu_stall), .o_wr(i_reg_wr), .o_rd(i_reg_rd),
                        .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));
    nv_access_ctrl #(.ADDR_W(9), .ATOMIC_RC_CYCLES(AT_N), .SPLIT_RC_CYCLES(SP_N)) dut (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_por_n(i_por_n), .i_clk_en(i_clk_en),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .i_global_irq_en(i_global_irq_en), .i_selfprog_busy(i_selfprog_busy), .i_rc_tick(i_rc_tick),
        .o_reg_rdata(o_reg_rdata), .o_cpu_stall(o_cpu_stall), .o_ready_irq(o_ready_irq),
        .o_prog_busy(o_prog_busy));
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        cpu.bus(1'b1, 1'b0, a, v);
        cpu.bus(1'b0, 1'b0, ~a, ~v);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        cpu.bus(1'b0, 1'b1, a, 8'h00);
        cpu.bus(1'b0, 1'b0, ~a, 8'hff);
        #1 v = o_reg_rdata;
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
        rd(a, d);
        chk(nm, e, d);
    endtask
    task automatic wait_idle;
        int n;
        for (n = 0; n < 100; n++) begin
            rd(8'h3f, d);
            if (d[1] === 1'b0 && i_selfprog_busy === 1'b0) break;
        end
        if (n == 100) begin
            fails++;
            close_out();
        end
    endtask
    task automatic wbyte(input logic [15:0] ix, input logic [7:0] v, input prog_mode_t m);
        wait_idle();
        wr(8'h41, ix[7:0]);
        wr(8'h42, ix[15:8]);
        wr(8'h40, v);
        wr(8'h3f, {2'h0, m, 4'h4});
        wr(8'h3f, {2'h0, m, 4'h2});
    endtask
    // Busy length is taken at the falling edge, before the monitor clears it
    task automatic wait_done(input int nt);
        int n;
        @(negedge i_sys_clk);
        for (n = 0; n < 400 && o_prog_busy !== 1'b0; n++) @(negedge i_sys_clk);
        tests_run++;
        if (n == 400 || blen < 2 * nt - 1 || blen > 2 * nt + 4) begin
            fails++;
            $display("BAD busy_len expected %0d seen %0d", 2 * nt, blen);
        end
        if (n == 400) close_out();
    endtask
    task automatic pulse_rst;
        @(posedge i_sys_clk);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
    endtask
    initial begin
        repeat (8) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        i_por_n <= 1'b1;
        rdc("ctl_rst", 8'h3f, 8'h00);
        rdc("val_rst", 8'h40, 8'h00);
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            wr(ra[i], rw[i]);
            rdc("row", ra[i], re[i]);
        end
        $display("test rows done");
        wr(8'h3f, 8'h04);
        rdc("arm_set", 8'h3f, 8'h04);
        repeat (6) cpu.bus(1'b0, 1'b0, 8'h00, 8'h00);
        rdc("arm_gone", 8'h3f, 8'h00);
        wr(8'h3f, 8'h02);
        rdc("no_arm", 8'h3f, 8'h00);
        wr(8'h3f, 8'h34);
        wr(8'h3f, 8'h32);
        rd(8'h3f, d);
        chk("mode11", 8'h30, d & 8'h32);
        $display("test arm done");
        wr(8'h3f, 8'h08);
        @(posedge i_sys_clk);
        i_global_irq_en <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        #1 chk("irq_on", 8'h01, {7'h00, o_ready_irq});
        @(posedge i_sys_clk);
        i_selfprog_busy <= 1'b1;
        wr(8'h3f, 8'h0c);
        wr(8'h3f, 8'h0a);
        rd(8'h3f, d);
        chk("sp_refuse", 8'h00, d & 8'h02);
        chk("irq_sp", 8'h00, {7'h00, o_ready_irq});
        @(posedge i_sys_clk);
        i_selfprog_busy <= 1'b0;
        i_global_irq_en <= 1'b0;
        $display("test irq done");
        for (i = 0; i < 3; i++) begin
            wbyte(16'h01ff, cv[i], pm[i]);
            wr(8'h41, 8'h00);
            wr(8'h3f, 8'h31);
            rdc("busy_ctl", 8'h3f, {2'h0, pm[i], 4'h2});
            rdc("busy_idx", 8'h41, 8'hff);
            wait_done(i == 0 ? AT_N : SP_N);
            rdc("done_ctl", 8'h3f, {2'h0, pm[i], 4'h0});
            wait_idle();
            wr(8'h3f, 8'h01);
            rdc("cell", 8'h40, ce[i]);
        end
        $display("test modes done");
        wbyte(16'h00ff, 8'h00, PM_ERASE);
        pulse_rst();
        #1 chk("busy_rst", 8'h01, {7'h00, o_prog_busy});
        rdc("mode_kept", 8'h3f, 8'h12);
        wait_done(SP_N);
        wr(8'h41, 8'hff);
        wr(8'h3f, 8'h01);
        rdc("rst_cell", 8'h40, 8'hff);
        wr(8'h3f, 8'h20);
        pulse_rst();
        rdc("mode_clr", 8'h3f, 8'h00);
        $display("test reset_busy done");
        close_out();
    end
endmodule // nv_access_ctrl_test
bind nv_access_ctrl nv_access_ctrl_props props (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_por_n(i_por_n), .i_clk_en(i_clk_en),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_global_irq_en(i_global_irq_en), .i_selfprog_busy(i_selfprog_busy), .o_reg_rdata(o_reg_rdata),
    .o_cpu_stall(o_cpu_stall), .o_ready_irq(o_ready_irq), .o_prog_busy(o_prog_busy));
